// file: hw/mdsio_pkg.sv
// How it works
// - Motion flag holds a minimum ms time
// - In-position only when stopped and within range
// - Completion offset shifts the converging range
// - Torque flag; push mode uses push limit
// - Positive below negative: outside-window zone
// - Positive above negative: inclusive inside window
// - Equal bounds: exact position match only
// - Zones evaluated while stopped too
// - Zones 1,2 command; zone 3 feedback
// - Six signed 24-bit bounds, reset zero
// - Tick every 7.2 degrees, 50 per rev
// - Busy flag during internal or maintenance work
// - Echo outputs mirror their paired inputs
// - Limit in homing to homing, else overtravel
// - Overtravel detection enable, default on
// - Overtravel stop: immediate or deceleration
// - Sensor contact logic open or closed
// - Home sensor used in 3-sensor mode
// - Slit combines with home sensor
// - Network input bit drives direct output
// - Direct input reported on network bit
package mdsio_pkg;

    // Timing
    localparam int CLK_PERIOD_NS = 5;
    localparam int MS_UNIT_NS = 1000000;
    localparam int MS_CYCLES_DEF = MS_UNIT_NS / CLK_PERIOD_NS;
    localparam int MS_CNT_W = 18;

    // Register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_INPOS = 8'h04;
    localparam logic [7:0] OFF_PUSH = 8'h08;
    localparam logic [7:0] OFF_TICK = 8'h0C;
    localparam logic [7:0] OFF_ZONE0 = 8'h10;
    localparam logic [7:0] OFF_NET_IN = 8'h28;
    localparam logic [7:0] OFF_OUT_MAP = 8'h2C;
    localparam logic [7:0] OFF_IN_MAP = 8'h30;
    localparam logic [7:0] OFF_STATUS = 8'h34;
    localparam logic [7:0] OFF_NET_OUT = 8'h38;

    // Control fields
    localparam int CTRL_W = 17;
    localparam int CF_MIN_MS = 0;
    localparam int CF_OT_EN = 8;
    localparam int CF_OT_DECEL = 9;
    localparam int CF_LS_NC = 10;
    localparam int CF_HOME_SENSOR_INPUT_NC = 11;
    localparam int CF_SLIT_NC = 12;
    localparam int CF_HMODE = 13;
    localparam int CF_SLIT_USE = 15;
    localparam int CF_SW_BUSY = 16;
    localparam logic [1:0] HMODE_3SENSOR = 2'h1;

    // Completion fields
    localparam int IF_RANGE = 0;
    localparam int IF_OFFSET = 8;

    // Reset values
    localparam logic [CTRL_W-1:0] CTRL_RST = 17'h00100;
    localparam logic [23:0] INPOS_RST = 24'h000012;
    localparam logic [9:0] PUSH_RST = 10'h000;
    localparam logic [15:0] TICK_RST = 16'h0014;
    localparam logic [23:0] BOUND_RST = 24'h000000;

    // Sizes
    localparam int ZONES = 3;
    localparam int BOUNDS = 6;
    localparam int RELAYS = 16;
    localparam int DOUTS = 4;
    localparam int DINS = 8;
    localparam int ECHOS = 9;
    localparam int SYNC_W = ECHOS + DINS;

endpackage

// file: hw/mdsio_sync.sv
`timescale 1ns/1ps
module mdsio_sync #(
    parameter int W = 1
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [W-1:0] pin,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } mdsio_sync_type;

    mdsio_sync_type st_r;
    mdsio_sync_type st_nxt;

    // Three stages; a change counts once stages two and three agree
    always_comb begin
        st_nxt.s1 = pin;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        st_nxt.q = (st_r.s2 & st_r.s3) | (st_r.q & (st_r.s2 | st_r.s3));
        if (sys_rst) begin
            st_nxt = '0;
        end
    end

    always_ff @(posedge sys_clk) begin
        st_r <= st_nxt;
    end

    assign q = st_r.q;
endmodule // mdsio_sync

// file: hw/mdsio_zone.sv
`timescale 1ns/1ps
module mdsio_zone (
    input wire logic [23:0] pos,
    input wire logic [23:0] pos_bound,
    input wire logic [23:0] neg_bound,
    output logic hit
);
    logic signed [23:0] p;
    logic signed [23:0] hi;
    logic signed [23:0] lo;

    // Signed two's-complement comparison of position against bounds
    assign p = signed'(pos);
    assign hi = signed'(pos_bound);
    assign lo = signed'(neg_bound);

    always_comb begin
        if (hi < lo) begin
            hit = (p <= hi) || (p >= lo);
        end else if (hi > lo) begin
            hit = (p >= lo) && (p <= hi);
        end else begin
            hit = (p == hi);
        end
    end
endmodule // mdsio_zone

// file: hw/mdsio_top.sv
`timescale 1ns/1ps
module mdsio_top
    import mdsio_pkg::*;
#(
    parameter int MS_CYCLES = MS_CYCLES_DEF
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic motor_operating,
    input wire logic homing_active,
    input wire logic push_active,
    input wire logic [23:0] cmd_position,
    input wire logic [23:0] fb_position,
    input wire logic [15:0] angle_deviation,
    input wire logic [9:0] load_torque,
    input wire logic [9:0] torque_range,
    input wire logic maint_cmd_busy,
    input wire logic op_start_pin,
    input wire logic data_sel_pin,
    input wire logic free_pin,
    input wire logic current_on_pin,
    input wire logic stop_pin,
    input wire logic plus_limit_sensor,
    input wire logic minus_limit_sensor,
    input wire logic home_sensor_input,
    input wire logic slit_sensor_input,
    input wire logic [7:0] direct_input,
    output logic motion_active_flag,
    output logic in_position_flag,
    output logic torque_limit_flag,
    output logic zone_window_flag_1,
    output logic zone_window_flag_2,
    output logic zone_window_flag_3,
    output logic shaft_angle_tick,
    output logic internal_processing_flag,
    output logic [8:0] echo_output,
    output logic overtravel_stop,
    output logic stop_decel,
    output logic homing_limit_event,
    output logic home_detect,
    output logic [3:0] direct_output,
    output logic [15:0] network_output
);

    ////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        logic [CTRL_W-1:0] ctrl;
        logic [23:0] inpos;
        logic [9:0] push;
        logic [15:0] tick_step;
        logic [BOUNDS-1:0][23:0] bound;
        logic [15:0] net_in;
        logic [31:0] out_map;
        logic [31:0] in_map;
        logic wr_pend;
        logic [7:0] wa;
        logic [31:0] rdata;
        logic hready;
        logic [MS_CNT_W-1:0] ms_cnt;
        logic [7:0] hold;
        logic op_d;
        logic armed;
        logic [23:0] last_pos;
        logic mv;
        logic inpos_f;
        logic trq_over;
        logic [ZONES-1:0] zone;
        logic tick;
        logic busy;
        logic [ECHOS-1:0] echo;
        logic ot_stop;
        logic ot_decel;
        logic home_lim;
        logic home_det;
        logic [DOUTS-1:0] dout;
        logic [RELAYS-1:0] nout;
    } mdsio_state_type;

    mdsio_state_type st_r;
    mdsio_state_type st_nxt;

    logic [SYNC_W-1:0] sync_q;
    logic [ZONES-1:0] zone_hit;
    logic [DOUTS-1:0] dout_c;
    logic [RELAYS-1:0] nout_c;
    logic lim_p;
    logic lim_m;
    logic home_a;
    logic slit_a;
    logic take;
    logic signed [16:0] dev;
    logic [16:0] dev_mag;
    logic signed [24:0] delta;
    logic signed [24:0] step;
    logic [9:0] torque_lim;

    // Relay number held in the low nibble of a map field
    function automatic logic [3:0] relay_idx(input logic [7:0] f);
        return f[3:0];
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Pin synchronisers and sensor logic

    mdsio_sync #(
        .W(SYNC_W)
    ) u_sync (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .pin({direct_input, slit_sensor_input, home_sensor_input,
              minus_limit_sensor, plus_limit_sensor, stop_pin,
              current_on_pin, free_pin, data_sel_pin, op_start_pin}),
        .q(sync_q)
    );

    // Contact logic: a closed-type sensor is active when its pin is low
    assign lim_p = sync_q[5] ^ st_r.ctrl[CF_LS_NC];
    assign lim_m = sync_q[6] ^ st_r.ctrl[CF_LS_NC];
    assign home_a = sync_q[7] ^ st_r.ctrl[CF_HOME_SENSOR_INPUT_NC];
    assign slit_a = sync_q[8] ^ st_r.ctrl[CF_SLIT_NC];

    ////////////////////////////////////////////////////////////////////
    // Zones and relay routing

    // Zones 1 and 2 watch command position, zone 3 feedback
    generate
        for (genvar z = 0; z < ZONES; z++) begin : g_zone
            mdsio_zone u_zone (
                .pos(z < 2 ? cmd_position : fb_position),
                .pos_bound(st_r.bound[2*z]),
                .neg_bound(st_r.bound[2*z+1]),
                .hit(zone_hit[z])
            );
        end
        for (genvar j = 0; j < DOUTS; j++) begin : g_dout
            // Bit 7 of each field enables the route
            assign dout_c[j] = st_r.out_map[8*j+7] &
                st_r.net_in[relay_idx(st_r.out_map[8*j +: 8])];
        end
    endgenerate

    // Direct inputs routed onto network output bits
    always_comb begin
        nout_c = '0;
        for (int j = 0; j < DOUTS; j++) begin
            if (st_r.in_map[8*j+7] && sync_q[ECHOS + 32'(st_r.in_map[8*j+4 +: 3])]) begin
                nout_c[relay_idx(st_r.in_map[8*j +: 8])] = 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Arithmetic helpers

    assign take = hsel & htrans[1] & hready;
    assign dev = 17'(signed'(angle_deviation)) - 17'(signed'(st_r.inpos[IF_OFFSET +: 16]));
    assign dev_mag = dev[16] ? 17'(-dev) : 17'(dev);
    assign delta = 25'(signed'(fb_position)) - 25'(signed'(st_r.last_pos));
    assign step = signed'({9'h000, st_r.tick_step});
    assign torque_lim = push_active ? st_r.push : torque_range;

    ////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        st_nxt = st_r;
        st_nxt.tick = 1'b0;
        st_nxt.hready = 1'b1;

        // Data phase of a write
        st_nxt.wr_pend = 1'b0;
        if (st_r.wr_pend) begin
            case (st_r.wa)
                OFF_CTRL: begin
                    st_nxt.ctrl = hwdata[CTRL_W-1:0];
                end
                OFF_INPOS: begin
                    st_nxt.inpos = hwdata[23:0];
                end
                OFF_PUSH: begin
                    st_nxt.push = hwdata[9:0];
                end
                OFF_TICK: begin
                    st_nxt.tick_step = hwdata[15:0];
                end
                OFF_NET_IN: begin
                    st_nxt.net_in = hwdata[15:0];
                end
                OFF_OUT_MAP: begin
                    st_nxt.out_map = hwdata;
                end
                OFF_IN_MAP: begin
                    st_nxt.in_map = hwdata;
                end
                default: begin
                    for (int i = 0; i < BOUNDS; i++) begin
                        if (st_r.wa == OFF_ZONE0 + 8'(4 * i)) begin
                            st_nxt.bound[i] = hwdata[23:0];
                        end
                    end
                end
            endcase
        end

        // Address phase: latch writes, fetch read data
        if (take) begin
            st_nxt.wr_pend = hwrite;
            st_nxt.wa = haddr[7:0];
            st_nxt.rdata = 32'h00000000;
            case (haddr[7:0])
                OFF_CTRL: st_nxt.rdata = 32'(st_r.ctrl);
                OFF_INPOS: st_nxt.rdata = 32'(st_r.inpos);
                OFF_PUSH: st_nxt.rdata = 32'(st_r.push);
                OFF_TICK: st_nxt.rdata = 32'(st_r.tick_step);
                OFF_NET_IN: st_nxt.rdata = 32'(st_r.net_in);
                OFF_OUT_MAP: st_nxt.rdata = st_r.out_map;
                OFF_IN_MAP: st_nxt.rdata = st_r.in_map;
                OFF_STATUS: st_nxt.rdata = {17'h00000, st_r.home_det, st_r.home_lim,
                    st_r.ot_decel, st_r.ot_stop, st_r.busy, st_r.zone,
                    st_r.trq_over, st_r.inpos_f, st_r.mv, lim_m, lim_p, home_a, slit_a};
                OFF_NET_OUT: st_nxt.rdata = 32'(st_r.nout);
                default: begin
                    for (int i = 0; i < BOUNDS; i++) begin
                        if (haddr[7:0] == OFF_ZONE0 + 8'(4 * i)) begin
                            st_nxt.rdata = 32'(st_r.bound[i]);
                        end
                    end
                end
            endcase
        end

        // Motion flag with minimum on time from each start
        st_nxt.op_d = motor_operating;
        if (motor_operating && !st_r.op_d) begin
            st_nxt.hold = st_r.ctrl[CF_MIN_MS +: 8];
            st_nxt.ms_cnt = '0;
        end else if (st_r.hold != 8'h00) begin
            if (st_r.ms_cnt == MS_CNT_W'(MS_CYCLES - 1)) begin
                st_nxt.ms_cnt = '0;
                st_nxt.hold = st_r.hold - 8'h01;
            end else begin
                st_nxt.ms_cnt = st_r.ms_cnt + MS_CNT_W'(1);
            end
        end
        st_nxt.mv = motor_operating | (st_nxt.hold != 8'h00);

        // Completion only while stopped and inside the range
        st_nxt.inpos_f = !st_nxt.mv &&
            (dev_mag <= 17'(st_r.inpos[IF_RANGE +: 8]));
        st_nxt.trq_over = load_torque > torque_lim;
        st_nxt.zone = zone_hit;
        st_nxt.busy = maint_cmd_busy | st_r.ctrl[CF_SW_BUSY];
        st_nxt.echo = sync_q[ECHOS-1:0];

        // Shaft tick per angle step, either direction
        if (!st_r.armed) begin
            st_nxt.armed = 1'b1;
            st_nxt.last_pos = fb_position;
        end else if (st_r.tick_step != 16'h0000) begin
            if (delta >= step) begin
                st_nxt.last_pos = st_r.last_pos + st_r.tick_step[15:0];
                st_nxt.tick = 1'b1;
            end else if (delta <= -step) begin
                st_nxt.last_pos = st_r.last_pos - 24'(st_r.tick_step);
                st_nxt.tick = 1'b1;
            end
        end

        // Limits: homing gets the event, otherwise overtravel stop
        st_nxt.home_lim = homing_active & (lim_p | lim_m);
        st_nxt.ot_stop = !homing_active & st_r.ctrl[CF_OT_EN] & (lim_p | lim_m);
        st_nxt.ot_decel = st_nxt.ot_stop & st_r.ctrl[CF_OT_DECEL];
        st_nxt.home_det = homing_active &&
            st_r.ctrl[CF_HMODE +: 2] == HMODE_3SENSOR && home_a &&
            (!st_r.ctrl[CF_SLIT_USE] || slit_a);
        st_nxt.dout = dout_c;
        st_nxt.nout = nout_c;

        if (sys_rst) begin
            st_nxt = '0;
            st_nxt.ctrl = CTRL_RST;
            st_nxt.inpos = INPOS_RST;
            st_nxt.push = PUSH_RST;
            st_nxt.tick_step = TICK_RST;
            st_nxt.bound = {BOUNDS{BOUND_RST}};
            st_nxt.hready = 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        st_r <= st_nxt;
    end

    ////////////////////////////////////////////////////////////////////
    // Outputs

    assign hrdata = st_r.rdata;
    assign hreadyout = st_r.hready;
    assign hresp = 1'b0;
    assign motion_active_flag = st_r.mv;
    assign in_position_flag = st_r.inpos_f;
    assign torque_limit_flag = st_r.trq_over;
    assign zone_window_flag_1 = st_r.zone[0];
    assign zone_window_flag_2 = st_r.zone[1];
    assign zone_window_flag_3 = st_r.zone[2];
    assign shaft_angle_tick = st_r.tick;
    assign internal_processing_flag = st_r.busy;
    assign echo_output = st_r.echo;
    assign overtravel_stop = st_r.ot_stop;
    assign stop_decel = st_r.ot_decel;
    assign homing_limit_event = st_r.home_lim;
    assign home_detect = st_r.home_det;
    assign direct_output = st_r.dout;
    assign network_output = st_r.nout;

    ////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    sequence op_start_s;
        !motor_operating ##1 motor_operating;
    endsequence

    sequence stop_steady_s;
        stop_pin [*5];
    endsequence

    move_follow_a: assert property (op_start_s |=> motion_active_flag)
        else $error("motion flag missed operation start");
    inpos_gate_a: assert property (in_position_flag |-> !motion_active_flag)
        else $error("in-position while moving");
    torque_push_a: assert property (push_active && load_torque > st_r.push
        |=> torque_limit_flag)
        else $error("push torque limit not flagged");
    zone_equal_a: assert property (st_r.bound[0] == st_r.bound[1] &&
        $stable(st_r.bound[0]) |=> zone_window_flag_1 == ($past(cmd_position) ==
        $past(st_r.bound[0])))
        else $error("equal-bound zone mismatch");
    tick_step_a: assert property (shaft_angle_tick |-> $past(st_r.tick_step) != 16'h0000)
        else $error("tick with zero step");
    busy_flag_a: assert property (maint_cmd_busy |=> internal_processing_flag)
        else $error("busy flag missed maintenance");
    stop_echo_a: assert property (stop_steady_s |=> echo_output[4])
        else $error("stop echo not following pin");
    ot_homing_a: assert property (overtravel_stop |-> !$past(homing_active))
        else $error("overtravel during homing");
    decel_sel_a: assert property (stop_decel |-> overtravel_stop &&
        $past(st_r.ctrl[CF_OT_DECEL]))
        else $error("decel stop without setting");
    relay_out_a: assert property (st_r.out_map[7] && $stable(st_r.out_map)
        |=> direct_output[0] == $past(st_r.net_in[relay_idx(st_r.out_map[7:0])]))
        else $error("relay output mismatch");

endmodule // mdsio_top

// file: dv/mdsio_plant.sv
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////
// Far side: sensor contacts, direct inputs and motor shaft feedback
module mdsio_plant (
    input wire logic sys_clk,
    input wire logic slew,
    input wire logic [23:0] fb_target,
    input wire logic [16:0] pin_req,
    output logic [23:0] fb_position,
    output logic [16:0] pins
);
    // Contacts change only at clock edges
    always_ff @(posedge sys_clk) begin
        pins <= pin_req;
    end
    // Shaft walks one step a cycle when slewing; gear kept at 20 steps a tick
    always_ff @(posedge sys_clk) begin
        if (!slew) begin
            fb_position <= fb_target;
        end else if (fb_position != fb_target) begin
            fb_position <= fb_position + 24'h000001;
        end
    end
endmodule // mdsio_plant

// file: dv/tb_motor_driver_status_io.sv
`timescale 1ns/1ps
module tb_motor_driver_status_io;
    import mdsio_pkg::*;
    localparam int MSC = 10;
    logic sys_clk, sys_rst, hsel, hwrite, hreadyout, hresp, slew;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic mo, hom, push, maint;
    logic [23:0] cmd, fbt, fb;
    logic [15:0] dev, net_out;
    logic [9:0] load, trq;
    logic [16:0] pin_req, pins;
    logic mv, inp, trq_flag, z1, z2, z3, tick, busy, ot, dec, hle, hdet;
    logic [8:0] echo;
    logic [3:0] dout;
    int err_total, samples_checked, cyc, seed;
    //////////////////////////////////////////////////////////////////////
    mdsio_top #(.MS_CYCLES(MSC)) u_dut (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .motor_operating(mo), .homing_active(hom), .push_active(push),
        .cmd_position(cmd), .fb_position(fb), .angle_deviation(dev),
        .load_torque(load), .torque_range(trq), .maint_cmd_busy(maint),
        .op_start_pin(pins[0]), .data_sel_pin(pins[1]), .free_pin(pins[2]),
        .current_on_pin(pins[3]), .stop_pin(pins[4]), .plus_limit_sensor(pins[5]),
        .minus_limit_sensor(pins[6]), .home_sensor_input(pins[7]),
        .slit_sensor_input(pins[8]), .direct_input(pins[16:9]),
        .motion_active_flag(mv), .in_position_flag(inp), .torque_limit_flag(trq_flag),
        .zone_window_flag_1(z1), .zone_window_flag_2(z2), .zone_window_flag_3(z3),
        .shaft_angle_tick(tick), .internal_processing_flag(busy), .echo_output(echo),
        .overtravel_stop(ot), .stop_decel(dec), .homing_limit_event(hle),
        .home_detect(hdet), .direct_output(dout), .network_output(net_out));
    mdsio_plant u_plant (.sys_clk(sys_clk), .slew(slew), .fb_target(fbt),
        .pin_req(pin_req), .fb_position(fb), .pins(pins));
    //////////////////////////////////////////////////////////////////////
    // Clock at 200 MHz
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    // Hang guard
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            complete_run();
        end
    end
    //////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wait_c(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    // One AHB single transfer; waits on hready in both phases
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q);
        @(posedge sys_clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {24'h000000, a};
        @(posedge sys_clk);
        while (hreadyout !== 1'b1) @(posedge sys_clk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge sys_clk);
        while (hreadyout !== 1'b1) @(posedge sys_clk);
        q = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        ahb(1'b1, a, d, q);
    endtask
    task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        ahb(1'b0, a, 32'h00000000, q);
        chk(nm, q, exp);
        chk("resp", hresp, 32'h00000000);
    endtask
    function automatic logic zone_exp(input logic signed [23:0] p, pb, nb);
        if (pb < nb) return (p <= pb) || (p >= nb);
        if (pb > nb) return (p >= nb) && (p <= pb);
        return p == pb;
    endfunction
    function automatic logic inpos_exp(input logic [15:0] d, o, input logic [7:0] r);
        int x;
        x = int'($signed(d)) - int'($signed(o));
        if (x < 0) x = -x;
        return x <= int'(r);
    endfunction
    task automatic complete_run;
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    //////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        logic [31:0] v, q, q2;
        logic [15:0] off, e;
        logic [7:0] rng;
        logic [23:0] bnd [6];
        logic a;
        int n;
        seed = 32'h8239FD8F;
        err_total = 0;
        samples_checked = 0;
        cyc = 0;
        {hsel, hwrite, mo, hom, push, maint} = 6'h00;
        haddr = 32'h0;
        hwdata = 32'h0;
        htrans = 2'h0;
        hsize = 3'h2;
        {cmd, fbt, dev, load, trq, pin_req} = 0;
        slew = 1'b0;
        sys_rst = 1'b1;
        wait_c(5);
        sys_rst <= 1'b0;
        // Defaults and an unmapped place
        rdc("ctrl", OFF_CTRL, 32'h00000100);
        rdc("inpos", OFF_INPOS, 32'h00000012);
        for (int b = 0; b < 6; b++) begin
            rdc("bound", OFF_ZONE0 + 8'(4 * b), 32'h00000000);
        end
        rdc("unmapped", 8'h3C, 32'h00000000);
        // Shaft walks 100 steps: five ticks of 20
        fbt <= 24'd100;
        slew <= 1'b1;
        n = 0;
        repeat (130) begin
            @(posedge sys_clk);
            if (tick === 1'b1) n++;
        end
        chk("ticks", n, 5);
        slew <= 1'b0;
        // Minimum on time of 3 ms after a two-cycle move
        wr(OFF_CTRL, 32'h00000103);
        mo <= 1'b1;
        wait_c(2);
        mo <= 1'b0;
        wait_c(18);
        chk("move_hold", mv, 1'b1);
        wait_c(20);
        chk("move_end", mv, 1'b0);
        wr(OFF_CTRL, 32'h00000100);
        // Completion window with offset, boundary every fifth pass
        for (int i = 0; i < 40; i++) begin
            off = 16'($random(seed) % 30);
            rng = 8'($unsigned($random(seed)) % 181);
            v = $random(seed);
            dev <= (i % 5 == 0) ? off + 16'(rng) : 16'($random(seed) % 200);
            mo <= v[0] & v[1];
            wr(OFF_INPOS, {8'h00, off, rng});
            wait_c(3);
            chk("inpos", inp, inpos_exp(dev, off, rng) & !(v[0] & v[1]));
            chk("move", mv, v[0] & v[1]);
        end
        mo <= 1'b0;
        // Torque limit, push limit replacing the range
        for (int i = 0; i < 30; i++) begin
            v = $random(seed);
            if (i == 0) v[30:10] = {1'b0, v[29:20], v[29:20]};
            wr(OFF_PUSH, {22'h0, v[9:0]});
            load <= v[19:10];
            trq <= v[29:20];
            push <= v[30];
            wait_c(3);
            chk("torque", trq_flag, v[30] ? v[19:10] > v[9:0] : v[19:10] > v[29:20]);
        end
        push <= 1'b0;
        // Zone windows while stopped, all three bound orders
        for (int i = 0; i < 60; i++) begin
            for (int b = 0; b < 6; b++) begin
                bnd[b] = (i % 2) ? 24'($random(seed)) : 24'($random(seed) % 40);
                if (i % 4 == 0 && b % 2 == 1) bnd[b] = bnd[b - 1];
                wr(OFF_ZONE0 + 8'(4 * b), {8'h00, bnd[b]});
            end
            cmd <= (i % 8 == 0) ? bnd[0] : 24'($random(seed) % 40);
            fbt <= (i % 8 == 0) ? bnd[4] : 24'($random(seed) % 40);
            wait_c(4);
            chk("zone1", z1, zone_exp(cmd, bnd[0], bnd[1]));
            chk("zone2", z2, zone_exp(cmd, bnd[2], bnd[3]));
            chk("zone3", z3, zone_exp(fb, bnd[4], bnd[5]));
        end
        // Echo of raw pin levels
        for (int i = 0; i < 20; i++) begin
            pin_req <= 17'($random(seed));
            wait_c(8);
            chk("echo", echo, pin_req[8:0]);
        end
        // Overtravel: enable, decel, contact logic, homing
        for (int k = 0; k < 16; k++) begin
            wr(OFF_CTRL, {21'h0, k[0], k[3], k[2], 8'h00});
            hom <= k[1];
            pin_req <= 17'($random(seed));
            wait_c(8);
            a = (pin_req[5] ^ k[0]) | (pin_req[6] ^ k[0]);
            chk("ot", ot, k[2] & a & !k[1]);
            chk("decel", dec, k[2] & a & !k[1] & k[3]);
            if (k[2]) chk("hlim", hle, a & k[1]);
        end
        // Home detection: modes, slit use, contact logic
        hom <= 1'b1;
        for (int k = 0; k < 16; k++) begin
            wr(OFF_CTRL, {16'h0, k[2], k[1], k[0], k[0] ^ k[1], k[3], 11'h100});
            pin_req <= 17'($random(seed));
            wait_c(8);
            a = (pin_req[7] ^ k[3]) & (!k[2] | (pin_req[8] ^ k[0] ^ k[1]));
            chk("home", hdet, (k[1:0] == HMODE_3SENSOR) & a);
        end
        hom <= 1'b0;
        // Busy from maintenance work or software
        for (int k = 0; k < 4; k++) begin
            wr(OFF_CTRL, {15'h0, k[1], 16'h0100});
            maint <= k[0];
            wait_c(3);
            chk("busy", busy, k[0] | k[1]);
        end
        // Relay routing both ways
        for (int i = 0; i < 8; i++) begin
            v = $random(seed);
            q = $random(seed) & 32'h0F0F0F0F | 32'h80808080;
            q2 = $random(seed) & 32'h7F7F7F7F | 32'h80808080;
            wr(OFF_NET_IN, v);
            wr(OFF_OUT_MAP, q);
            wr(OFF_IN_MAP, q2);
            pin_req <= 17'($random(seed));
            wait_c(8);
            for (int j = 0; j < 4; j++) begin
                chk("dout", dout[j], v[q[8 * j +: 4]]);
            end
            e = 16'h0000;
            for (int j = 0; j < 4; j++) begin
                if (pin_req[9 + q2[8 * j + 4 +: 3]]) e[q2[8 * j +: 4]] = 1'b1;
            end
            chk("netout", net_out, e);
            rdc("netreg", OFF_NET_OUT, {16'h0000, e});
        end
        complete_run();
    end
endmodule // tb_motor_driver_status_io
